// File: core/bio_ctrl.v
// Purpose: Binary output functions, debounced binary input, cleaning timer
// Assumes: Avalon-MM slave, 32-bit data, one clock, flow as signed word
// Notes: Batch volume counting lives in software; hardware tracks phase
//
// What this block does
// - Direction mode asserts output while reported flow is negative.
// - Failure mode asserts output at least five seconds per error.
// - Failure longer than hold keeps output on for whole error.
// - Limit mode asserts when flow passes limit above or below.
// - Limit releases only after flow returns inside by hysteresis.
// - Four limit comparison modes, each with selectable polarity.
// - Cleaning mode output active exactly while cleaning runs.
// - Batch running mode output active during running phase.
// - Batch outputs support advance by time or by volume remaining.
// - Batch stop pulse mode emits one pulse at end or advance.
// - Input change accepted only after level holds 60 ms.
// - Input in start mode starts or resumes the batch.
// - Input in hold mode suspends batch keeping counted volume.
// - Input in stop mode ends batch at once, reloads preset.
// - Input in reset mode clears chosen totalizers and work time.
// - Input in clean mode starts cleaning if module fitted.
// - A cleaning cycle lasts one minute with measurement frozen.
// - During cleaning the flow captured before start is reported.
// - Single-shot cleaning runs one cycle; mode returns off as it starts.
// - Power-up cleaning starts one cycle after each power-on.
// - Interval cleaning every 1 to 255 whole hours.
// - Interval timer starts on entry; optional real-time hour align.
// - Stop pulse length 10 ms to 2550 ms in 10 ms steps.
// - With both advances set, whichever is reached first acts.
`include "bio_defines.vh"
module bio_ctrl #(
    parameter integer MS_CYC = `BIO_MS_CYC,
    parameter integer MS_PER_HOUR = 3600000
)(
    input wire clk,
    input wire rst_n,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire signed [31:0] flow_rate,
    input wire flow_valid,
    input wire error_active,
    input wire [31:0] batch_remain,
    input wire batch_done,
    input wire clean_fitted,
    input wire [4:0] rtc_hour,
    input wire rtc_hour_tick,
    input wire bin_in,
    output reg [3:0] bin_out,
    output reg signed [31:0] flow_report,
    output reg [1:0] batch_phase,
    output reg batch_reload,
    output reg totals_clear,
    output reg [3:0] totals_sel,
    output reg clean_drive
);
    localparam [1:0] PH_STOP = 2'h0;
    localparam [1:0] PH_HOLD = 2'h1;
    localparam [1:0] PH_RUN = 2'h2;
    localparam [1:0] PH_FIN = 2'h3;
    localparam [31:0] HOLD_MS = `BIO_HOLD_MS;
    localparam [31:0] DEB_MS = `BIO_DEB_MS;
    localparam [31:0] CLEAN_MS = `BIO_CLEAN_S * 1000;

    // Absolute value of a signed flow word
    function [31:0] abs32;
        input signed [31:0] v;
        begin
            abs32 = v[31] ? (~v + 32'h1) : v;
        end
    endfunction

    reg [31:0] outcfg_q;   // Per output: [3:0] fn+pol, [5:4] limit mode
    reg [31:0] limit_q;
    reg [31:0] hyst_q;
    reg [31:0] adv_q;      // Volume advance
    reg [31:0] tadv_q;     // Time advance in ms
    reg [31:0] batch_q;    // [2:0] input fn, [7:4] totals sel, [15:8] pulse
    reg [31:0] clean_q;    // [1:0] mode, [15:8] hours, [20:16] hour, [24] align
    reg signed [31:0] held_q;
    reg [15:0] ms_div_q;
    reg ms_tick_q;
    reg [12:0] fail_ms_q;
    reg [3:0] lim_q;
    reg [3:0] pulse_on_q;
    reg [11:0] pulse_ms_q [0:3];
    reg adv_hit_q;
    reg [6:0] deb_ms_q;
    reg deb_lvl_q;
    reg deb_rise_q;
    reg [15:0] clean_ms_q;
    reg cleaning_q;
    reg pwr_pending_q;
    reg [31:0] hr_ms_q;
    reg [7:0] hours_q;
    reg int_due_q;
    reg clean_req_q;
    wire [31:0] aflow = abs32(flow_rate);
    wire fail_on = error_active || (fail_ms_q != 13'h0);
    wire [31:0] tleft;
    wire adv_now;
    integer i;

    // Remaining time estimate: remaining volume per unit flow, whole ms
    assign tleft = (aflow == 32'h0) ? 32'hFFFFFFFF : batch_remain / aflow;
    // Either advance triggers, whichever is reached first
    assign adv_now = (adv_q != 32'h0 && batch_remain <= adv_q) ||
                     (tadv_q != 32'h0 && tleft <= tadv_q);

    // Bus slave: one wait cycle, then the answer
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end
        else
        begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest)
            begin
                case (avs_address[5:2])
                    `BIO_REG_OUTCFG: avs_readdata <= outcfg_q;
                    `BIO_REG_LIMIT: avs_readdata <= limit_q;
                    `BIO_REG_HYST: avs_readdata <= hyst_q;
                    `BIO_REG_ADV: avs_readdata <= adv_q;
                    `BIO_REG_BATCH: avs_readdata <= batch_q;
                    `BIO_REG_CLEAN: avs_readdata <= clean_q;
                    `BIO_REG_STATUS: avs_readdata <= {20'h0, cleaning_q,
                        deb_lvl_q, batch_phase, bin_out, lim_q};
                    `BIO_REG_HELD: avs_readdata <= held_q;
                    `BIO_REG_TIMEADV: avs_readdata <= tadv_q;
                    default: avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // Configuration writes, byte lanes honoured
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            outcfg_q <= 32'h0;
            limit_q <= 32'h0;
            hyst_q <= 32'h0;
            adv_q <= 32'h0;
            tadv_q <= 32'h0;
            batch_q <= 32'h00000100;
            clean_q <= 32'h00000100;
            hours_q <= 8'h0;
        end
        else
        begin
            if (avs_write && !avs_waitrequest)
            begin
                for (i = 0; i < 4; i = i + 1)
                begin
                    if (avs_byteenable[i])
                    begin
                        case (avs_address[5:2])
                            `BIO_REG_OUTCFG: outcfg_q[i*8+:8] <=
                                avs_writedata[i*8+:8];
                            `BIO_REG_LIMIT: limit_q[i*8+:8] <=
                                avs_writedata[i*8+:8];
                            `BIO_REG_HYST: hyst_q[i*8+:8] <=
                                avs_writedata[i*8+:8];
                            `BIO_REG_ADV: adv_q[i*8+:8] <=
                                avs_writedata[i*8+:8];
                            `BIO_REG_BATCH: batch_q[i*8+:8] <=
                                avs_writedata[i*8+:8];
                            `BIO_REG_CLEAN: clean_q[i*8+:8] <=
                                avs_writedata[i*8+:8];
                            `BIO_REG_TIMEADV: tadv_q[i*8+:8] <=
                                avs_writedata[i*8+:8];
                            default: ;
                        endcase
                    end
                end
                // Entering the interval restarts the hour count
                if (avs_address[5:2] == `BIO_REG_CLEAN)
                    hours_q <= 8'h0;
            end
            else if (cleaning_q && clean_q[1:0] == `BIO_CM_SHOT)
                clean_q[1:0] <= `BIO_CM_OFF;
            else if (ms_tick_q && hr_ms_q == MS_PER_HOUR - 1)
                hours_q <= (hours_q >= clean_q[15:8] - 8'h1) ? 8'h0
                    : hours_q + 8'h1;
        end
    end

    // Millisecond tick and hour counter
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            ms_div_q <= 16'h0;
            ms_tick_q <= 1'b0;
            hr_ms_q <= 32'h0;
        end
        else
        begin
            ms_tick_q <= (ms_div_q == MS_CYC - 1);
            ms_div_q <= (ms_div_q == MS_CYC - 1) ? 16'h0 : ms_div_q + 16'h1;
            if (avs_write && !avs_waitrequest &&
                avs_address[5:2] == `BIO_REG_CLEAN)
                hr_ms_q <= 32'h0;
            else if (ms_tick_q)
                hr_ms_q <= (hr_ms_q == MS_PER_HOUR - 1) ? 32'h0
                    : hr_ms_q + 32'h1;
        end
    end

    // Input debounce: level must hold 60 ms
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            deb_ms_q <= 7'h0;
            deb_lvl_q <= 1'b0;
            deb_rise_q <= 1'b0;
        end
        else
        begin
            deb_rise_q <= 1'b0;
            if (bin_in == deb_lvl_q)
                deb_ms_q <= 7'h0;
            else if (ms_tick_q)
            begin
                if (deb_ms_q == DEB_MS[6:0] - 7'h1)
                begin
                    deb_lvl_q <= bin_in;
                    deb_rise_q <= bin_in;
                    deb_ms_q <= 7'h0;
                end
                else
                    deb_ms_q <= deb_ms_q + 7'h1;
            end
        end
    end

    // Batch phase and input actions
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            batch_phase <= PH_STOP;
            batch_reload <= 1'b0;
            totals_clear <= 1'b0;
            totals_sel <= 4'h0;
            adv_hit_q <= 1'b0;
        end
        else
        begin
            batch_reload <= 1'b0;
            totals_clear <= 1'b0;
            totals_sel <= batch_q[7:4];
            if (deb_rise_q && batch_q[2:0] == `BIO_IN_STOP)
            begin
                batch_phase <= PH_STOP;
                batch_reload <= 1'b1;
            end
            else if (deb_rise_q && batch_q[2:0] == `BIO_IN_HOLD &&
                     batch_phase == PH_RUN)
                batch_phase <= PH_HOLD;
            else if (deb_rise_q && batch_q[2:0] == `BIO_IN_START &&
                     batch_phase != PH_RUN)
            begin
                if (batch_phase != PH_HOLD)
                    batch_reload <= 1'b1;
                batch_phase <= PH_RUN;
                adv_hit_q <= 1'b0;
            end
            else
            begin
                case (batch_phase)
                    PH_RUN:
                    begin
                        if (batch_done)
                            batch_phase <= PH_STOP;
                        else if (adv_now)
                            batch_phase <= PH_FIN;
                        if (adv_now || batch_done)
                            adv_hit_q <= 1'b1;
                    end
                    PH_FIN:
                        if (batch_done)
                            batch_phase <= PH_STOP;
                    default: ;
                endcase
            end
            if (deb_rise_q && batch_q[2:0] == `BIO_IN_RESET)
                totals_clear <= 1'b1;
        end
    end

    // Cleaning scheduler and one-minute cycle
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cleaning_q <= 1'b0;
            clean_ms_q <= 16'h0;
            clean_drive <= 1'b0;
            pwr_pending_q <= 1'b1;
            int_due_q <= 1'b0;
            clean_req_q <= 1'b0;
            held_q <= 32'h0;
            flow_report <= 32'h0;
        end
        else
        begin
            int_due_q <= clean_q[1:0] == `BIO_CM_INT && (clean_q[24] ?
                (rtc_hour_tick && rtc_hour == clean_q[20:16] &&
                 hours_q == 8'h0) :
                (ms_tick_q && hr_ms_q == MS_PER_HOUR - 1 &&
                 hours_q >= clean_q[15:8] - 8'h1));
            clean_req_q <= (deb_rise_q && batch_q[2:0] == `BIO_IN_CLEAN) ||
                (clean_q[1:0] == `BIO_CM_SHOT) || int_due_q ||
                (pwr_pending_q && clean_q[1:0] == `BIO_CM_PWR);
            if (clean_q[1:0] == `BIO_CM_PWR && cleaning_q)
                pwr_pending_q <= 1'b0;
            if (!cleaning_q && clean_req_q && clean_fitted)
            begin
                cleaning_q <= 1'b1;
                clean_ms_q <= 16'h0;
                held_q <= flow_report;
            end
            else if (cleaning_q && ms_tick_q)
            begin
                if (clean_ms_q == CLEAN_MS[15:0] - 16'h1)
                    cleaning_q <= 1'b0;
                clean_ms_q <= clean_ms_q + 16'h1;
            end
            clean_drive <= cleaning_q;
            // Measurement frozen while cleaning
            if (!cleaning_q && flow_valid)
                flow_report <= flow_rate;
            else if (cleaning_q)
                flow_report <= held_q;
        end
    end

    // Failure hold, limit hysteresis, pulses and output drive
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            fail_ms_q <= 13'h0;
            lim_q <= 4'h0;
            pulse_on_q <= 4'h0;
            bin_out <= 4'h0;
            for (i = 0; i < 4; i = i + 1)
                pulse_ms_q[i] <= 12'h0;
        end
        else
        begin
            if (error_active)
                fail_ms_q <= HOLD_MS[12:0];
            else if (ms_tick_q && fail_ms_q != 13'h0)
                fail_ms_q <= fail_ms_q - 13'h1;
            for (i = 0; i < 4; i = i + 1)
            begin
                case (outcfg_q[i*8+4+:2])
                    `BIO_LM_OVER: lim_q[i] <= lim_q[i] ?
                        (flow_rate > $signed(limit_q - hyst_q)) :
                        (flow_rate > $signed(limit_q));
                    `BIO_LM_UNDER: lim_q[i] <= lim_q[i] ?
                        (flow_rate < $signed(limit_q + hyst_q)) :
                        (flow_rate < $signed(limit_q));
                    `BIO_LM_ABS_OVER: lim_q[i] <= lim_q[i] ?
                        (aflow > limit_q - hyst_q) : (aflow > limit_q);
                    default: lim_q[i] <= lim_q[i] ?
                        (aflow < limit_q + hyst_q) : (aflow < limit_q);
                endcase
                // Stop pulse: length in 10 ms steps
                if (outcfg_q[i*8+:3] == `BIO_FN_STOPP &&
                    batch_phase == PH_RUN && (adv_now || batch_done) &&
                    !adv_hit_q)
                begin
                    pulse_on_q[i] <= 1'b1;
                    pulse_ms_q[i] <= {batch_q[15:8], 4'h0} -
                        {4'h0, batch_q[15:8]} * 12'h6;
                end
                else if (ms_tick_q && pulse_on_q[i])
                begin
                    if (pulse_ms_q[i] <= 12'h1)
                        pulse_on_q[i] <= 1'b0;
                    pulse_ms_q[i] <= pulse_ms_q[i] - 12'h1;
                end
                case (outcfg_q[i*8+:3])
                    `BIO_FN_DIR: bin_out[i] <= flow_report[31] ^
                        outcfg_q[i*8+3];
                    `BIO_FN_FAIL: bin_out[i] <= fail_on ^ outcfg_q[i*8+3];
                    `BIO_FN_LIMIT: bin_out[i] <= lim_q[i] ^ outcfg_q[i*8+3];
                    `BIO_FN_CLEAN: bin_out[i] <= cleaning_q ^
                        outcfg_q[i*8+3];
                    `BIO_FN_RUN: bin_out[i] <= (batch_phase == PH_RUN &&
                        !adv_now) ^ outcfg_q[i*8+3];
                    `BIO_FN_STOPP: bin_out[i] <= pulse_on_q[i] ^
                        outcfg_q[i*8+3];
                    default: bin_out[i] <= outcfg_q[i*8+3];
                endcase
            end
        end
    end
endmodule // bio_ctrl

// File: core/bio_defines.vh
// Purpose: Shared constants for the binary I/O function controller
// Assumes: 20 MHz system clock
// Notes: Offsets are word indices of 32-bit registers
`ifndef BIO_DEFINES_VH
`define BIO_DEFINES_VH
`define BIO_CLK_HZ 20000000
`define BIO_HOLD_MS 5000
`define BIO_DEB_MS 60
`define BIO_CLEAN_S 60
`define BIO_MS_CYC (`BIO_CLK_HZ / 1000)
`define BIO_PSTEP_MS 10
// Register offsets (word indices, byte address divided by four)
`define BIO_REG_OUTCFG 4'h0
`define BIO_REG_LIMIT 4'h1
`define BIO_REG_HYST 4'h2
`define BIO_REG_ADV 4'h3
`define BIO_REG_BATCH 4'h4
`define BIO_REG_CLEAN 4'h5
`define BIO_REG_STATUS 4'h6
`define BIO_REG_HELD 4'h7
`define BIO_REG_TIMEADV 4'h8
// Output function codes
`define BIO_FN_OFF 3'h0
`define BIO_FN_DIR 3'h1
`define BIO_FN_FAIL 3'h2
`define BIO_FN_LIMIT 3'h3
`define BIO_FN_CLEAN 3'h4
`define BIO_FN_RUN 3'h5
`define BIO_FN_STOPP 3'h6
// Input function codes
`define BIO_IN_OFF 3'h0
`define BIO_IN_START 3'h1
`define BIO_IN_HOLD 3'h2
`define BIO_IN_STOP 3'h3
`define BIO_IN_RESET 3'h4
`define BIO_IN_CLEAN 3'h5
// Cleaning modes
`define BIO_CM_OFF 2'h0
`define BIO_CM_SHOT 2'h1
`define BIO_CM_PWR 2'h2
`define BIO_CM_INT 2'h3
// Limit compare modes
`define BIO_LM_OVER 2'h0
`define BIO_LM_UNDER 2'h1
`define BIO_LM_ABS_OVER 2'h2
`define BIO_LM_ABS_UNDER 2'h3
`endif

// File: verification/bio_ctrl_checker.sv
// Purpose: Port-level assertions for the binary I/O controller
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound from the bench top file
module bio_checker #(
    parameter int MS_CYC = 20000
)(
    input wire clk,
    input wire rst_n,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire bin_in,
    input wire [3:0] bin_out,
    input wire signed [31:0] flow_report,
    input wire [1:0] batch_phase,
    input wire batch_reload,
    input wire totals_clear,
    input wire clean_fitted,
    input wire clean_drive
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CLEAN_CYC = 60000 * MS_CYC;
    localparam int DEB_CYC = 60 * MS_CYC;
    logic [31:0] run_q;
    logic [31:0] still_q;
    logic last_q;
    // Length of the cleaning run and of the steady input level
    always_ff @(posedge clk)
    begin
        run_q <= (rst_n && clean_drive) ? run_q + 32'h1 : 32'h0;
        still_q <= (!rst_n || bin_in != last_q) ? 32'h0 : still_q + 32'h1;
        last_q <= bin_in;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // A request seen while waiting, then a one-cycle answer
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    AST_ANS_ONE: assert property (s_req |=> s_ans) // Bus answer timing
        else $error("Bus answer not one cycle after request");
    AST_ANS_CAUSE: assert property (!avs_waitrequest |->
        $past(avs_read) || $past(avs_write)) // Bus answer cause
        else $error("Bus answer without a request");
    AST_RST_IDLE: assert property ($rose(rst_n) |-> bin_out == 4'h0 &&
        batch_phase == 2'h0 && !clean_drive && avs_waitrequest) // Reset
        else $error("Outputs not idle after reset");
    AST_CLEAN_LEN: assert property ($fell(clean_drive) |->
        run_q >= CLEAN_CYC - 1 && run_q <= CLEAN_CYC + 1)
        else $error("Cleaning run has wrong length");
    AST_CLEAN_FRZ: assert property (clean_drive && $past(clean_drive) |->
        $stable(flow_report))
        else $error("Reported flow moved during cleaning");
    AST_CLEAN_FIT: assert property ($rose(clean_drive) |->
        clean_fitted)
        else $error("Cleaning started without module");
    AST_CLR_DEB: assert property ($rose(totals_clear) |->
        still_q >= DEB_CYC - 2)
        else $error("Input acted on before debounce time");
    AST_CLR_ONE: assert property (totals_clear |=> !totals_clear)
        else $error("Totals clear longer than one cycle");
    AST_RELOAD_STOP: assert property (batch_reload |->
        batch_phase == 2'h0 ||
        (batch_phase == 2'h2 && $past(batch_phase) != 2'h1))
        else $error("Preset reload without batch stop");
endmodule // bio_checker

// File: verification/bio_contact.sv
// Purpose: Field contact wired to the binary input
// Assumes: Bench calls press right after a rising clock edge
// Notes: Contact open, input low, between closures
module bio_contact (
    input wire logic clk,
    output logic bin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        bin_in = 1'b0;
    end
    // Close for n cycles, then stay open long enough to settle
    task automatic press(input int n);
        bin_in <= 1'b1;
        repeat (n) @(posedge clk);
        bin_in <= 1'b0;
        repeat (100) @(posedge clk);
    endtask
endmodule // bio_contact

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the binary I/O controller
// Assumes: One-cycle millisecond and ten-millisecond hour
// Notes: Registers reached through Avalon-MM tasks
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic signed [31:0] flow_rate = 32'h0000_0000;
    logic error_active = 1'b0;
    logic [31:0] batch_remain = 32'h0000_0000;
    logic clean_fitted = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic flow_valid = 1'b1;
    logic batch_done = 1'b0;
    logic [4:0] rtc_hour = 5'h00;
    logic rtc_hour_tick = 1'b0;
    logic bin_in;
    logic [3:0] bin_out;
    logic signed [31:0] flow_report;
    logic [1:0] batch_phase;
    logic batch_reload;
    logic totals_clear;
    logic [3:0] totals_sel;
    logic clean_drive;
    int err_count = 0;
    int n_checks = 0;
    int reload_cnt = 0;
    int clr_cnt = 0;
    int cnt;
    logic [31:0] lim_flow [4] = '{32'h0000_0032, 32'h0000_0096,
        32'h0000_005F, 32'hFFFF_FF6A};
    logic [3:0] lim_exp [4] = '{4'hA, 4'h5, 4'hF, 4'h6};
    always #25 clk = ~clk;
    bio_ctrl #(.MS_CYC(1), .MS_PER_HOUR(10)) DUT (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .flow_rate(flow_rate), .flow_valid(flow_valid),
        .error_active(error_active), .batch_remain(batch_remain),
        .batch_done(batch_done), .clean_fitted(clean_fitted),
        .rtc_hour(rtc_hour), .rtc_hour_tick(rtc_hour_tick),
        .bin_in(bin_in),
        .bin_out(bin_out), .flow_report(flow_report),
        .batch_phase(batch_phase), .batch_reload(batch_reload),
        .totals_clear(totals_clear), .totals_sel(totals_sel),
        .clean_drive(clean_drive));
    bio_contact contact (.clk(clk), .bin_in(bin_in));
    // Count single-cycle action pulses
    always @(posedge clk)
    begin
        if (batch_reload === 1'b1)
            reload_cnt <= reload_cnt + 1;
        if (totals_clear === 1'b1)
            clr_cnt <= clr_cnt + 1;
    end
    task automatic check(input [31:0] got, input [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Hold the request until waitrequest is seen low
    task automatic bus_wr(input [5:0] a, input [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input [5:0] a, input [31:0] exp);
        logic [31:0] v;
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        v = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
        check(v, exp);
    endtask
    task automatic stop_test;
        $display("Mismatches %0d of %0d checks", err_count, n_checks);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial
    begin
        tick(95000);
        err_count++;
        stop_test();
    end
    initial
    begin
        tick(20);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(6'h10, 32'h0000_0100);
        rd_chk(6'h14, 32'h0000_0100);
        bus_wr(6'h3C, 32'hFFFF_FFFF);
        rd_chk(6'h3C, 32'h0000_0000);
        bus_wr(6'h00, 32'h0000_0901);
        flow_rate <= 32'hFFFF_FFFB;
        tick(4);
        check(bin_out, 4'h1);
        flow_rate <= 32'h0000_0005;
        tick(4);
        check(bin_out, 4'h2);
        flow_valid <= 1'b0;
        flow_rate <= 32'hFFFF_FFFB;
        tick(4);
        check(bin_out, 4'h2);
        flow_valid <= 1'b1;
        // One output per limit compare mode
        flow_rate <= lim_flow[0];
        avs_byteenable <= 4'h1;
        bus_wr(6'h04, 32'hFFFF_FF64);
        avs_byteenable <= 4'hF;
        bus_wr(6'h08, 32'h0000_000A);
        bus_wr(6'h00, 32'h3323_1303);
        for (int i = 0; i < 4; i++)
        begin
            flow_rate <= lim_flow[i];
            tick(4);
            check(bin_out, lim_exp[i]);
        end
        bus_wr(6'h00, 32'h0000_0002);
        error_active <= 1'b1;
        tick(10);
        error_active <= 1'b0;
        tick(4000);
        check(bin_out, 4'h1);
        tick(1100);
        check(bin_out, 4'h0);
        error_active <= 1'b1;
        tick(7000);
        check(bin_out, 4'h1);
        error_active <= 1'b0;
        tick(5100);
        check(bin_out, 4'h0);
        // Batch driven from the contact, 30 ms stop pulse
        bus_wr(6'h00, 32'h0006_0500);
        bus_wr(6'h0C, 32'h0000_01F4);
        batch_remain <= 32'h0000_03E8;
        bus_wr(6'h10, 32'h0000_0301);
        contact.press(30);
        check(batch_phase, 2'h0);
        contact.press(80);
        check(batch_phase, 2'h2);
        check(bin_out, 4'h2);
        bus_wr(6'h10, 32'h0000_0302);
        contact.press(80);
        check(batch_phase, 2'h1);
        check(bin_out[1], 1'b0);
        bus_wr(6'h10, 32'h0000_0301);
        contact.press(80);
        check(batch_phase, 2'h2);
        batch_remain <= 32'h0000_0190;
        cnt = 0;
        repeat (200)
        begin
            @(posedge clk);
            if (bin_out[2] === 1'b1)
                cnt++;
        end
        check(cnt, 32'h0000_001E);
        check(bin_out[1], 1'b0);
        batch_done <= 1'b1;
        tick(2);
        check(batch_phase, 2'h0);
        batch_done <= 1'b0;
        cnt = reload_cnt;
        bus_wr(6'h10, 32'h0000_0303);
        contact.press(80);
        check(batch_phase, 2'h0);
        check(reload_cnt - cnt, 32'h1);
        cnt = clr_cnt;
        bus_wr(6'h10, 32'h0000_0154);
        contact.press(80);
        check(clr_cnt - cnt, 32'h1);
        check(totals_sel, 4'h5);
        bus_wr(6'h10, 32'h0000_0105);
        contact.press(80);
        check(clean_drive, 1'b0);
        // Single-shot cleaning with the flow frozen
        clean_fitted <= 1'b1;
        flow_rate <= 32'h0000_004D;
        bus_wr(6'h00, 32'h0400_0000);
        bus_wr(6'h14, 32'h0000_0101);
        cnt = 0;
        while (clean_drive !== 1'b1 && cnt < 20)
        begin
            @(posedge clk);
            cnt++;
        end
        flow_rate <= 32'hFFFF_FED4;
        tick(5);
        check(bin_out, 4'h8);
        check(flow_report, 32'h0000_004D);
        rd_chk(6'h14, 32'h0000_0100);
        cnt = 0;
        while (clean_drive === 1'b1 && cnt < 70000)
        begin
            @(posedge clk);
            cnt++;
        end
        check(cnt >= 59980 && cnt <= 60000, 32'h1);
        tick(5);
        check(bin_out, 4'h0);
        check(flow_report, 32'hFFFF_FED4);
        bus_wr(6'h14, 32'h0000_0203);
        tick(10);
        check(clean_drive, 1'b0);
        tick(20);
        check(clean_drive, 1'b1);
        // Reset in mid-clean returns everything to idle
        rst_n <= 1'b0;
        tick(20);
        rst_n <= 1'b1;
        tick(2);
        check(clean_drive, 1'b0);
        rd_chk(6'h14, 32'h0000_0100);
        bus_wr(6'h14, 32'h0105_1803);
        rtc_hour <= 5'h05;
        rtc_hour_tick <= 1'b1;
        tick(1);
        rtc_hour_tick <= 1'b0;
        tick(4);
        check(clean_drive, 1'b1);
        rst_n <= 1'b0;
        tick(20);
        rst_n <= 1'b1;
        bus_wr(6'h14, 32'h0000_0102);
        tick(4);
        check(clean_drive, 1'b1);
        stop_test();
    end
endmodule // tb_top
bind bio_ctrl bio_checker #(.MS_CYC(MS_CYC)) chk_i (
    .clk(clk), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .bin_in(bin_in), .bin_out(bin_out), .flow_report(flow_report),
    .batch_phase(batch_phase), .batch_reload(batch_reload),
    .totals_clear(totals_clear), .clean_fitted(clean_fitted),
    .clean_drive(clean_drive));
